// *** rtl/gpbd_ports.sv ***
`include "gpbd_regs.svh"

// Functional notes
// - Two eight-bit ports, per-pin direction bits
// - Direction one floats pin, zero drives latch
// - Latch register readable; read-modify-write uses latch
// - Shared active-low pull-up enable, control bit 7
// - Pull-up off on pins with direction bit zero
// - Pull-ups disabled after power-on reset
// - Port B 4:0 analog, read zero by default
// - Analog default cleared gives digital 4:0
// - Change detect on 7:4 inputs only
// - Compare with value captured at last port B read or write; OR sets flag
// - Change flag raises wake request
// - Persisting mismatch keeps setting the flag
// - Pin returning to captured value ends mismatch
// - Selector zero routes unit-2 on pin B3
// - Three port D pins carry PWM B,C,D
// - PWM pins are inputs after power-on reset
// - Slave port mode bit makes port D slave
// - Dual or quad PWM disables slave port
module gpbd_ports
	import gpbd_pkg::*;
#(
	parameter int PORT_W = 8
)
(
	input  wire logic           core_clk,
	input  wire logic           rst_n,
	input  wire logic [3:0]     reg_addr,
	input  wire logic [7:0]     reg_wdata,
	input  wire logic           reg_wr,
	input  wire logic           reg_rd,
	output logic [7:0]          reg_rdata,
	input  wire logic           port_b_analog_default,
	input  wire logic           ccu2_pin_select,
	input  wire logic           ccu2_out,
	input  wire logic           ccu2_out_en,
	input  wire logic [2:0]     pwm_out_bcd,
	input  wire logic           pwm_active,
	input  wire gpbd_pwm_mode_t pwm_mode,
	input  wire logic [7:0]     port_b_in,
	output logic [7:0]          port_b_out,
	output logic [7:0]          port_b_oe,
	output logic [7:0]          port_b_pullup,
	input  wire logic [7:0]     port_d_in,
	output logic [7:0]          port_d_out,
	output logic [7:0]          port_d_oe,
	output logic                slave_port_active,
	output logic                wake_req
);
	gpbd_req_t  req;
	gpbd_pins_t pb_d, pd_d;
	logic [7:0] port_b_direction_q, port_b_output_latch_q;
	logic [7:0] port_d_direction_q, port_d_output_latch_q;
	logic [7:0] interrupt_control_q, port_e_direction_q;
	logic       pullup_enable_n_q, port_change_flag_q;
	logic [7:0] analog_mask_q;
	logic [7:0] b_meta_q, b_sync_q, d_meta_q, d_sync_q;
	logic [3:0] captured_q;
	logic [3:0] mismatch;
	logic       slave_en;
	logic [7:0] pb_read, rdata_d;
	logic       wr_b, rd_b;

	// Every register and field map here is byte wide
	if (PORT_W != 8) begin : g_bad_width
		$error("gpbd_ports: PORT_W must be 8");
	end

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign wr_b = req.wr && req.addr == `GPBD_OFF_PORT_B_PINS;
	assign rd_b = req.rd && req.addr == `GPBD_OFF_PORT_B_PINS;

	// Pins come from outside the clock domain
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			b_meta_q <= 8'h00;
			b_sync_q <= 8'h00;
			d_meta_q <= 8'h00;
			d_sync_q <= 8'h00;
		end else begin
			b_meta_q <= port_b_in;
			b_sync_q <= b_meta_q;
			d_meta_q <= port_d_in;
			d_sync_q <= d_meta_q;
		end
	end

	// analog default: reset sets mask; first edge with strap low clears it
	// strap sampled by a clock edge, not by the reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			analog_mask_q <= `GPBD_ANALOG_MASK;
		else if (analog_mask_q == `GPBD_ANALOG_MASK && !port_b_analog_default)
			analog_mask_q <= 8'h00;
	end
	// Limitation: the analog mask has no software release here; a strap high keeps 4:0 reading zero

	assign pb_read = b_sync_q & ~analog_mask_q;

	// direction and latch registers, port write hits latch
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_b_direction_q    <= `GPBD_DIR_RST;
			port_b_output_latch_q <= `GPBD_LAT_RST;
			port_d_direction_q    <= `GPBD_DIR_RST;
			port_d_output_latch_q <= `GPBD_LAT_RST;
			port_e_direction_q    <= `GPBD_DIRE_RST;
			pullup_enable_n_q     <= 1'b1;
			interrupt_control_q   <= 8'h00;
		end else if (req.wr) begin
			case (req.addr)
				`GPBD_OFF_PORT_B_PINS, `GPBD_OFF_PORT_B_OUTPUT_LATCH: port_b_output_latch_q <= req.wdata;
				`GPBD_OFF_DIRB:                  port_b_direction_q    <= req.wdata;
				`GPBD_OFF_PORT_D_PINS, `GPBD_OFF_PORT_D_OUTPUT_LATCH: port_d_output_latch_q <= req.wdata;
				`GPBD_OFF_DIRD:                  port_d_direction_q    <= req.wdata;
				`GPBD_OFF_DIRE:                  port_e_direction_q    <= req.wdata;
				`GPBD_OFF_INTERRUPT_CONTROL_TWO: pullup_enable_n_q <= req.wdata[`GPBD_PULLUP_N_BIT];
				`GPBD_OFF_INTERRUPT_CONTROL:  interrupt_control_q <= req.wdata;
				default: ;
			endcase
		end
	end

	// capture monitored bits on any port B pins read or write
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			captured_q <= 4'h0;
		else if (rd_b || wr_b)
			captured_q <= pb_read[7:4];
	end

	// mismatch clears itself when pin returns
	assign mismatch = (pb_read[7:4] ^ captured_q) & port_b_direction_q[7:4];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			port_change_flag_q <= 1'b0;
		else if (|mismatch)
			port_change_flag_q <= 1'b1;
		else if (req.wr && req.addr == `GPBD_OFF_INTERRUPT_CONTROL)
			port_change_flag_q <= req.wdata[`GPBD_CHANGE_BIT];
	end

	// dual or quad PWM blocks slave port
	assign slave_en = port_e_direction_q[`GPBD_SLAVE_BIT] &&
		!(pwm_active && pwm_mode != GPBD_PWM_SINGLE);

	always_comb begin
		pb_d.o  = port_b_output_latch_q;
		pb_d.oe = ~port_b_direction_q;
		// unit-2 takes pin B3 when selector is zero
		if (!ccu2_pin_select) begin
			pb_d.o[3]  = ccu2_out;
			pb_d.oe[3] = ccu2_out_en;
		end
		pd_d.o  = port_d_output_latch_q;
		pd_d.oe = ~port_d_direction_q;
		// PWM B on port D 5 when wider than single; C,D on 7:6 in quad only
		// reset state keeps these pins as inputs
		if (pwm_active && pwm_mode != GPBD_PWM_SINGLE) begin
			pd_d.o[5]  = pwm_out_bcd[0];
			pd_d.oe[5] = ~port_d_direction_q[5];
			if (pwm_mode == GPBD_PWM_QUAD) begin
				pd_d.o[7:6]  = pwm_out_bcd[2:1];
				pd_d.oe[7:6] = ~port_d_direction_q[7:6];
			end
		end
		// slave port: bus drives nothing from the latch side
		if (slave_en)
			pd_d.oe = 8'h00;
	end

	always_comb begin
		case (req.addr)
			`GPBD_OFF_PORT_B_PINS:   rdata_d = pb_read;
			`GPBD_OFF_PORT_B_OUTPUT_LATCH:    rdata_d = port_b_output_latch_q;
			`GPBD_OFF_DIRB:    rdata_d = port_b_direction_q;
			`GPBD_OFF_PORT_D_PINS:   rdata_d = d_sync_q;
			`GPBD_OFF_PORT_D_OUTPUT_LATCH:    rdata_d = port_d_output_latch_q;
			`GPBD_OFF_DIRD:    rdata_d = port_d_direction_q;
			`GPBD_OFF_INTERRUPT_CONTROL:  rdata_d = {interrupt_control_q[7:1], port_change_flag_q};
			`GPBD_OFF_INTERRUPT_CONTROL_TWO: rdata_d = {pullup_enable_n_q, 7'h00};
			`GPBD_OFF_DIRE:    rdata_d = port_e_direction_q;
			default:           rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata         <= 8'h00;
			port_b_out        <= 8'h00;
			port_b_oe         <= 8'h00;
			port_b_pullup     <= 8'h00;
			port_d_out        <= 8'h00;
			port_d_oe         <= 8'h00;
			slave_port_active <= 1'b0;
			wake_req          <= 1'b0;
		end else begin
			reg_rdata         <= req.rd ? rdata_d : 8'h00;
			port_b_out        <= pb_d.o;
			port_b_oe         <= pb_d.oe;
			// pull-up only on pins with direction bit one; reset value disables
			port_b_pullup     <= {8{~pullup_enable_n_q}} & port_b_direction_q;
			port_d_out        <= pd_d.o;
			port_d_oe         <= pd_d.oe;
			slave_port_active <= slave_en;
			// flag requests wake from sleep or idle
			wake_req          <= port_change_flag_q;
		end
	end

	// Checks
	a_flag_on_mismatch: assert property (@(posedge core_clk) disable iff (!rst_n)
		|mismatch |=> port_change_flag_q) else $error("change flag not set on mismatch");
	a_output_excluded: assert property (@(posedge core_clk) disable iff (!rst_n)
		!port_b_direction_q[7] |-> !mismatch[3]) else $error("output pin joined comparison");
	a_pullup_output_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		!port_b_direction_q[0] |=> !port_b_pullup[0]) else $error("pull-up on output pin");
	a_drive_from_dir: assert property (@(posedge core_clk) disable iff (!rst_n)
		!slave_en && !pwm_active |=> port_d_oe == ~$past(port_d_direction_q)) else $error("port D enable wrong");
	a_read_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
		req.rd && req.addr == `GPBD_OFF_PORT_B_OUTPUT_LATCH |=> reg_rdata == $past(port_b_output_latch_q))
		else $error("latch readback wrong");
	a_analog_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		analog_mask_q[0] |-> !pb_read[0]) else $error("analog pin not zero");
	a_slave_blocked: assert property (@(posedge core_clk) disable iff (!rst_n)
		pwm_active && pwm_mode == GPBD_PWM_QUAD |=> !slave_port_active) else $error("slave port with quad PWM");
	a_wake_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
		port_change_flag_q |=> wake_req) else $error("no wake on change");
	a_write_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
		req.wr && req.addr == `GPBD_OFF_PORT_D_PINS |=> port_d_output_latch_q == $past(req.wdata))
		else $error("port write missed latch");

	a_b_oe_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
		ccu2_pin_select |=> port_b_oe == ~$past(port_b_direction_q))
		else $error("port B enable wrong");

	a_b_out_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
		ccu2_pin_select |=> port_b_out == $past(port_b_output_latch_q))
		else $error("port B drive value wrong");

	a_ccu2_pin_oe: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ccu2_pin_select |=> port_b_oe[3] == $past(ccu2_out_en))
		else $error("unit-2 enable not on pin");

	a_ccu2_pin_out: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ccu2_pin_select |=> port_b_out[3] == $past(ccu2_out))
		else $error("unit-2 value not on pin");

	a_pullup_all_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		pullup_enable_n_q |=> port_b_pullup == 8'h00)
		else $error("pull-up on while disabled");

	a_pullup_inputs_on: assert property (@(posedge core_clk) disable iff (!rst_n)
		!pullup_enable_n_q |=> port_b_pullup == $past(port_b_direction_q))
		else $error("pull-up pattern wrong");

	a_pullup_n_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		req.wr && req.addr == `GPBD_OFF_INTERRUPT_CONTROL_TWO |=> pullup_enable_n_q == $past(reg_wdata[`GPBD_PULLUP_N_BIT]))
		else $error("pull-up enable write lost");

	a_latch_b_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		req.wr && req.addr == `GPBD_OFF_PORT_B_PINS |=> port_b_output_latch_q == $past(reg_wdata))
		else $error("port B write missed latch");

	a_latch_b_direct: assert property (@(posedge core_clk) disable iff (!rst_n)
		req.wr && req.addr == `GPBD_OFF_PORT_B_OUTPUT_LATCH |=> port_b_output_latch_q == $past(reg_wdata))
		else $error("latch B write lost");

	a_dir_b_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		req.wr && req.addr == `GPBD_OFF_DIRB |=> port_b_direction_q == $past(reg_wdata))
		else $error("direction B write lost");

	a_dir_d_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		req.wr && req.addr == `GPBD_OFF_DIRD |=> port_d_direction_q == $past(reg_wdata))
		else $error("direction D write lost");

	a_latch_d_direct: assert property (@(posedge core_clk) disable iff (!rst_n)
		req.wr && req.addr == `GPBD_OFF_PORT_D_OUTPUT_LATCH |=> port_d_output_latch_q == $past(reg_wdata))
		else $error("latch D write lost");

	a_port_b_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		req.rd && req.addr == `GPBD_OFF_PORT_B_PINS |=> reg_rdata == $past(pb_read))
		else $error("port B read wrong");

	a_port_d_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		req.rd && req.addr == `GPBD_OFF_PORT_D_PINS |=> reg_rdata == $past(d_sync_q))
		else $error("port D read wrong");

	a_capture_on_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_b |=> captured_q == $past(pb_read[7:4]))
		else $error("read did not capture");

	a_flag_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(|mismatch) && req.wr && req.addr == `GPBD_OFF_INTERRUPT_CONTROL && !reg_wdata[`GPBD_CHANGE_BIT]
		|=> !port_change_flag_q) else $error("change flag clear lost");

	a_flag_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
		port_change_flag_q && !(req.wr && req.addr == `GPBD_OFF_INTERRUPT_CONTROL) |=> port_change_flag_q)
		else $error("change flag dropped");

	a_no_spurious_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		!port_change_flag_q && !(|mismatch) && !(req.wr && req.addr == `GPBD_OFF_INTERRUPT_CONTROL)
		|=> !port_change_flag_q) else $error("change flag set without cause");

	a_return_ends: assert property (@(posedge core_clk) disable iff (!rst_n)
		pb_read[7:4] == captured_q |-> mismatch == 4'h0)
		else $error("mismatch with equal pins");

	a_wake_drops: assert property (@(posedge core_clk) disable iff (!rst_n)
		!port_change_flag_q |=> !wake_req)
		else $error("wake without change flag");

	a_analog_nibble: assert property (@(posedge core_clk) disable iff (!rst_n)
		analog_mask_q != 8'h00 |-> pb_read[4:0] == 5'h00)
		else $error("analog pins not zero");

	a_strap_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
		!port_b_analog_default |=> analog_mask_q == 8'h00)
		else $error("analog mask kept with strap low");

	a_slave_d_float: assert property (@(posedge core_clk) disable iff (!rst_n)
		slave_port_active |-> port_d_oe == 8'h00)
		else $error("port D driven in slave mode");

	a_slave_from_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
		port_e_direction_q[`GPBD_SLAVE_BIT] && !pwm_active |=> slave_port_active)
		else $error("slave port not entered");

	a_slave_dual_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		pwm_active && pwm_mode == GPBD_PWM_DUAL |=> !slave_port_active)
		else $error("slave port with dual PWM");

	a_pwm_b_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
		pwm_active && pwm_mode != GPBD_PWM_SINGLE |=> port_d_out[5] == $past(pwm_out_bcd[0]))
		else $error("PWM B not on pin");

	a_pwm_cd_pins: assert property (@(posedge core_clk) disable iff (!rst_n)
		pwm_active && pwm_mode == GPBD_PWM_QUAD |=> port_d_out[7:6] == $past(pwm_out_bcd[2:1]))
		else $error("PWM C or D not on pin");

	a_d_out_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
		!pwm_active |=> port_d_out == $past(port_d_output_latch_q))
		else $error("port D drive value wrong");
endmodule

// *** common/gpbd_regs.svh ***
`ifndef GPBD_REGS_SVH
`define GPBD_REGS_SVH
// Register offsets on the plain register port
`define GPBD_OFF_PORT_B_PINS      4'h0
`define GPBD_OFF_PORT_B_OUTPUT_LATCH       4'h1
`define GPBD_OFF_DIRB       4'h2
`define GPBD_OFF_PORT_D_PINS      4'h3
`define GPBD_OFF_PORT_D_OUTPUT_LATCH       4'h4
`define GPBD_OFF_DIRD       4'h5
`define GPBD_OFF_INTERRUPT_CONTROL     4'h6
`define GPBD_OFF_INTERRUPT_CONTROL_TWO    4'h7
`define GPBD_OFF_DIRE       4'h8
// Field positions
`define GPBD_PULLUP_N_BIT   7
`define GPBD_CHANGE_BIT     0
`define GPBD_SLAVE_BIT      4
// Reset values
`define GPBD_DIR_RST        8'hff
`define GPBD_LAT_RST        8'h00
`define GPBD_INTERRUPT_CONTROL_TWO_RST    8'h80
`define GPBD_DIRE_RST       8'h07
`define GPBD_ANALOG_MASK    8'h1f
`endif

// *** common/gpbd_pkg.sv ***
package gpbd_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} gpbd_req_t;
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
	} gpbd_pins_t;
	typedef enum logic [1:0] {
		GPBD_PWM_SINGLE = 2'b00,
		GPBD_PWM_DUAL   = 2'b01,
		GPBD_PWM_QUAD   = 2'b11
	} gpbd_pwm_mode_t;
endpackage

// *** tb/gpbd_pin_model.sv ***
module gpbd_pin_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] drv_o,
	input  wire logic [7:0] drv_oe,
	input  wire logic [7:0] pull,
	input  wire logic [7:0] ext_v,
	input  wire logic [7:0] ext_en,
	output logic [7:0]      pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] flt_q = 8'h55;
	// Floating pins wander, so a stale level never passes for a read
	always @(posedge core_clk)
		flt_q <= ~flt_q;
	always_comb
		for (int i = 0; i < 8; i++)
			pin[i] = drv_oe[i] ? drv_o[i] : ext_en[i] ? ext_v[i] : pull[i] ? 1'b1 : flt_q[i];
endmodule

// *** tb/gpio_ports_b_d_change_irq_bench.sv ***
`include "gpbd_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module gpio_ports_b_d_change_irq_bench;
	import gpbd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic           core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0]     reg_addr = 0;
	logic [7:0]     reg_wdata = 0, reg_rdata, bv = 8'hff, dv = 0, r;
	logic           strap = 1, sel = 1, c_o = 0, c_en = 0, pwm_act = 0, slv, wake;
	logic [2:0]     pbcd = 0;
	gpbd_pwm_mode_t mode = GPBD_PWM_SINGLE;
	logic [7:0]     b_in, b_out, b_oe, b_pu, d_in, d_out, d_oe;
	int             num_errors = 0, comparisons = 0, seed = 95864;
	gpbd_ports u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_b_analog_default(strap),
		.ccu2_pin_select(sel), .ccu2_out(c_o), .ccu2_out_en(c_en), .pwm_out_bcd(pbcd),
		.pwm_active(pwm_act), .pwm_mode(mode), .port_b_in(b_in), .port_b_out(b_out), .port_b_oe(b_oe),
		.port_b_pullup(b_pu), .port_d_in(d_in), .port_d_out(d_out), .port_d_oe(d_oe),
		.slave_port_active(slv), .wake_req(wake));
	gpbd_pin_model u_pb (.core_clk(core_clk), .drv_o(b_out), .drv_oe(b_oe), .pull(b_pu), .ext_v(bv),
		.ext_en(8'hff), .pin(b_in));
	gpbd_pin_model u_pd (.core_clk(core_clk), .drv_o(d_out), .drv_oe(d_oe), .pull(8'h00), .ext_v(dv),
		.ext_en(8'hff), .pin(d_in));
	initial forever #4 core_clk = ~core_clk;
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		d = reg_rdata;
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask
	task automatic do_reset(input logic s);
		strap <= s;
		rst_n <= 1'b0;
		idle(16);
		rst_n <= 1'b1;
		idle(2);
	endtask
	task automatic give_verdict;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100us;
		num_errors++;
		give_verdict();
	end
	initial begin
		do_reset(1'b1);
		rc(`GPBD_OFF_PORT_B_PINS, 8'he0);
		rc(`GPBD_OFF_DIRB, `GPBD_DIR_RST);
		rc(`GPBD_OFF_DIRD, `GPBD_DIR_RST);
		rc(`GPBD_OFF_PORT_B_OUTPUT_LATCH, `GPBD_LAT_RST);
		rc(`GPBD_OFF_INTERRUPT_CONTROL_TWO, `GPBD_INTERRUPT_CONTROL_TWO_RST);
		rc(`GPBD_OFF_DIRE, `GPBD_DIRE_RST);
		rc(4'hf, 8'h00);
		`CHK(b_pu, 8'h00)
		`CHK(d_oe, 8'h00)
		// Second reset mid-run with the strap low
		do_reset(1'b0);
		rc(`GPBD_OFF_PORT_B_PINS, 8'hff);
		wr(`GPBD_OFF_DIRB, 8'h00);
		wr(`GPBD_OFF_DIRD, 8'h00);
		repeat (8) begin
			r = $random(seed);
			wr(`GPBD_OFF_PORT_B_PINS, r);
			wr(`GPBD_OFF_PORT_D_OUTPUT_LATCH, ~r);
			idle(3);
			rc(`GPBD_OFF_PORT_B_OUTPUT_LATCH, r);
			rc(`GPBD_OFF_PORT_B_PINS, r);
			rc(`GPBD_OFF_PORT_D_PINS, ~r);
			`CHK(b_oe, 8'hff)
			`CHK(d_out, ~r)
		end
		wr(`GPBD_OFF_DIRB, 8'h0f);
		wr(`GPBD_OFF_INTERRUPT_CONTROL_TWO, 8'h00);
		idle(2);
		`CHK(b_pu, 8'h0f)
		`CHK(b_oe, 8'hf0)
		wr(`GPBD_OFF_DIRB, 8'h7f);
		bv <= 8'h00;
		idle(4);
		rd(`GPBD_OFF_PORT_B_PINS, r);
		wr(`GPBD_OFF_INTERRUPT_CONTROL, 8'h00);
		wr(`GPBD_OFF_PORT_B_OUTPUT_LATCH, ~r);
		bv <= 8'h04;
		idle(4);
		// only pin changes, no port B polling
		rc(`GPBD_OFF_INTERRUPT_CONTROL, 8'h00);
		bv <= 8'h44;
		idle(4);
		rc(`GPBD_OFF_INTERRUPT_CONTROL, 8'h01);
		`CHK(wake, 1'b1)
		wr(`GPBD_OFF_INTERRUPT_CONTROL, 8'h00);
		rc(`GPBD_OFF_INTERRUPT_CONTROL, 8'h01);
		bv <= 8'h04;
		idle(4);
		wr(`GPBD_OFF_INTERRUPT_CONTROL, 8'h00);
		rc(`GPBD_OFF_INTERRUPT_CONTROL, 8'h00);
		bv <= 8'h24;
		idle(4);
		rd(`GPBD_OFF_PORT_B_PINS, r);
		idle(1);
		wr(`GPBD_OFF_INTERRUPT_CONTROL, 8'h00);
		rc(`GPBD_OFF_INTERRUPT_CONTROL, 8'h00);
		sel <= 1'b0;
		c_en <= 1'b1;
		c_o <= 1'b1;
		idle(3);
		`CHK({b_oe[3], b_out[3]}, 2'b11)
		wr(`GPBD_OFF_DIRE, 8'h17);
		idle(2);
		`CHK({slv, d_oe}, 9'h100)
		pwm_act <= 1'b1;
		pbcd <= 3'($random(seed));
		for (int m = 0; m < 3; m++) begin
			mode <= m == 0 ? GPBD_PWM_SINGLE : m == 1 ? GPBD_PWM_DUAL : GPBD_PWM_QUAD;
			idle(3);
			`CHK(slv, m == 0)
		end
		`CHK(d_out[7:5], pbcd)
		give_verdict();
	end
endmodule
